// ==== verilog/dvfs_pkg.sv ====
package dvfs_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned STALL_MAX_US     = 10;
   // longest stall time in clock cycles
   localparam int unsigned STALL_MAX_CYC    = STALL_MAX_US * CLK_MHZ;
   localparam int unsigned VCODE_W          = 6;
   localparam int unsigned RATIO_W          = 6;
   localparam int unsigned POINT_W          = VCODE_W + RATIO_W;
   localparam logic [5:0]  VCODE_RESET      = 6'h3F;
   localparam logic [5:0]  RATIO_RESET      = 6'h01;
   localparam int unsigned RAMP_CYC_DEF     = 16;
   localparam int unsigned LOCK_CYC_DEF     = 64;
   localparam int unsigned THERM_WAIT_DEF   = 20000;
   localparam logic [5:0]  VCODE_STEP       = 6'h01;
   typedef enum logic [2:0] {DVFS_IDLE, DVFS_VUP, DVFS_RELOCK, DVFS_VDN, DVFS_DONE} dvfs_state_t;
endpackage

// ==== verilog/dvfs_ramp.sv ====
`timescale 1ns/10ps
// steps the voltage code one count per ramp interval toward the target
module dvfs_ramp
   import dvfs_pkg::*;
#(
   parameter int unsigned RAMP_CYC = RAMP_CYC_DEF
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire logic [VCODE_W-1:0]   target,
   output logic      [VCODE_W-1:0]   code_q,
   output logic                      at_target
);
   localparam int unsigned CW = $clog2(RAMP_CYC + 1);
   logic [CW-1:0] tick_q;
   wire           tick_end = (tick_q == CW'(RAMP_CYC - 1));
   wire           go_up    = target > code_q;
   assign at_target = (target == code_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
         code_q <= VCODE_RESET;
      end else if (ce) begin
         tick_q <= (at_target || tick_end) ? '0 : tick_q + CW'(1);
         if (!at_target && tick_end) begin
            code_q <= go_up ? code_q + VCODE_STEP : code_q - VCODE_STEP;
         end
      end
   end
endmodule

// ==== verilog/dvfs_bus_gate.sv ====
`timescale 1ns/10ps
// bus input buffer and termination gating, one flop per line
module dvfs_bus_gate #(
   parameter int unsigned LINES = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             data_buffer_power_req_n,
   input  wire logic             priority_agent_req_n,
   input  wire logic [LINES-1:0] line_drive_low,
   output logic                  data_buf_en_q,
   output logic                  addr_buf_en_q,
   output logic      [LINES-1:0] odt_en_q
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_buf_en_q <= 1'b0;
         addr_buf_en_q <= 1'b0;
      end else if (ce) begin
         data_buf_en_q <= !data_buffer_power_req_n;
         addr_buf_en_q <= !priority_agent_req_n;
      end
   end

   genvar i;
   generate
      for (i = 0; i < LINES; i++) begin : g_odt
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               odt_en_q[i] <= 1'b1;
            end else if (ce) begin
               odt_en_q[i] <= !line_drive_low[i];
            end
         end
      end
   endgenerate

   property p_data_gate;
      @(posedge clk) disable iff (rst)
      ce |=> data_buf_en_q == !$past(data_buffer_power_req_n);
   endproperty
   a_data_gate: assert property (p_data_gate) else $error("data buffer gate wrong");

   property p_addr_gate;
      @(posedge clk) disable iff (rst)
      ce |=> addr_buf_en_q == !$past(priority_agent_req_n);
   endproperty
   a_addr_gate: assert property (p_addr_gate) else $error("addr buffer gate wrong");

   // every line, not just the first
   property p_odt;
      @(posedge clk) disable iff (rst)
      ce |=> odt_en_q == ~$past(line_drive_low);
   endproperty
   a_odt: assert property (p_odt) else $error("termination on while driving low");
endmodule

// ==== verilog/dvfs_ctrl.sv ====
`timescale 1ns/10ps
// Overview of operation
// - many operating points, chosen by software writes, no toggle pin
// - going faster: raise voltage code first, then relock the PLL
// - going slower: relock the PLL first, then lower voltage code
// - requests always accepted; one arriving mid-transition waits until it ends
// - voltage code moves one step per internal ramp interval
// - core unavailable at most 10 us per frequency change
// - block next request asserted during the frequency change
// - hot die forces move to programmed low operating point
// - after fixed wait, if cool, return to the prior point
// - pulse an interrupt for thermal down and thermal up moves
// - data input buffers on only while data power request active
// - address and control buffers off while priority request inactive
// - termination off on a line the device drives low
// - power status low from deep sleep entry until exit
// - 6-bit code, 0 is 1.708 V, all ones 0.700 V
// - voltage code driven by own push-pull logic
// - core clock is integer multiple of bus clock
module dvfs_ctrl
   import dvfs_pkg::*;
#(
   parameter int unsigned RAMP_CYC   = RAMP_CYC_DEF,
   parameter int unsigned LOCK_CYC   = LOCK_CYC_DEF,
   parameter int unsigned THERM_WAIT = THERM_WAIT_DEF,
   parameter int unsigned LINES      = 8
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   input  wire logic                        req_valid,
   input  wire logic [dvfs_pkg::VCODE_W-1:0] req_vcode,
   input  wire logic [dvfs_pkg::RATIO_W-1:0] req_ratio,
   input  wire logic [dvfs_pkg::VCODE_W-1:0] therm_low_vcode,
   input  wire logic [dvfs_pkg::RATIO_W-1:0] therm_low_ratio,
   input  wire logic                        therm_enable,
   input  wire logic                        therm_hot,
   input  wire logic                        pll_locked,
   input  wire logic                        sleep_state,
   input  wire logic                        deep_sleep_req_n,
   input  wire logic                        data_buffer_power_req_n,
   input  wire logic                        priority_agent_req_n,
   input  wire logic [LINES-1:0]            line_drive_low,
   output logic      [dvfs_pkg::VCODE_W-1:0] voltage_code_out,
   output logic      [dvfs_pkg::RATIO_W-1:0] core_ratio_q,
   output logic                             pll_relock_q,
   output logic                             block_next_req_n,
   output logic                             core_stall_q,
   output logic                             busy_q,
   output logic                             therm_active_q,
   output logic                             therm_down_irq_q,
   output logic                             therm_up_irq_q,
   output logic                             power_status_low_n,
   output logic                             data_buf_en_q,
   output logic                             addr_buf_en_q,
   output logic      [LINES-1:0]            odt_en_q
);
   import dvfs_pkg::*;

   localparam int unsigned LCW = $clog2(STALL_MAX_CYC + 1);
   localparam int unsigned TWW = $clog2(THERM_WAIT + 1);

   dvfs_state_t         state_q;
   dvfs_state_t         state_d;
   logic [VCODE_W-1:0]  vtarget_q;
   logic [RATIO_W-1:0]  tgt_ratio_q;
   logic [VCODE_W-1:0]  tgt_vcode_q;
   logic [POINT_W-1:0]  pend_q;
   logic                pend_valid_q;
   logic [POINT_W-1:0]  saved_q;
   logic [LCW-1:0]      lock_cnt_q;
   logic [TWW-1:0]      twait_q;
   logic                therm_down_go;
   logic                therm_up_go;
   logic [VCODE_W-1:0]  code_now;
   logic                ramp_done;
   logic                stall_d;
   logic                deep_q;

   dvfs_ramp #(.RAMP_CYC(RAMP_CYC)) u_ramp (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .target    (vtarget_q),
      .code_q    (code_now),
      .at_target (ramp_done)
   );

   dvfs_bus_gate #(.LINES(LINES)) u_gate (
      .clk                     (clk),
      .rst                     (rst),
      .ce                      (ce),
      .data_buffer_power_req_n (data_buffer_power_req_n),
      .priority_agent_req_n    (priority_agent_req_n),
      .line_drive_low          (line_drive_low),
      .data_buf_en_q           (data_buf_en_q),
      .addr_buf_en_q           (addr_buf_en_q),
      .odt_en_q                (odt_en_q)
   );

   assign voltage_code_out = code_now;

   wire idle_w     = (state_q == DVFS_IDLE);
   wire faster_w   = pend_q[POINT_W-1 -: RATIO_W] > core_ratio_q;
   wire slower_w   = pend_q[POINT_W-1 -: RATIO_W] < core_ratio_q;
   wire lock_end_w = pll_locked || (lock_cnt_q >= LCW'(STALL_MAX_CYC - 1));
   wire twait_end  = (twait_q == TWW'(THERM_WAIT - 1));
   // direction of the running move; pend_q may already hold a deferred one
   wire up_w       = (tgt_ratio_q > core_ratio_q);

   assign therm_down_go = therm_enable && therm_hot && !therm_active_q && idle_w && !pend_valid_q;
   assign therm_up_go   = therm_active_q && twait_end && !therm_hot && idle_w && !pend_valid_q;

   always_comb begin
      state_d = state_q;
      stall_d = 1'b0;
      case (state_q)
         DVFS_IDLE: begin
            if (pend_valid_q) begin
               if (faster_w) begin
                  state_d = DVFS_VUP;
               end else if (slower_w) begin
                  state_d = DVFS_RELOCK;
                  stall_d = 1'b1;
               end else begin
                  state_d = DVFS_VDN;
               end
            end
         end
         DVFS_VUP: begin
            if (ramp_done) begin
               state_d = DVFS_RELOCK;
               stall_d = 1'b1;
            end
         end
         DVFS_RELOCK: begin
            stall_d = !lock_end_w;
            if (lock_end_w) begin
               state_d = up_w ? DVFS_DONE : DVFS_VDN;
            end
         end
         DVFS_VDN: begin
            if (ramp_done) begin
               state_d = DVFS_DONE;
            end
         end
         DVFS_DONE: begin
            state_d = DVFS_IDLE;
         end
         default: state_d = DVFS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q      <= DVFS_IDLE;
         core_stall_q <= 1'b0;
         lock_cnt_q   <= '0;
      end else if (ce) begin
         state_q      <= state_d;
         core_stall_q <= stall_d;
         lock_cnt_q   <= stall_d ? lock_cnt_q + LCW'(1) : '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         block_next_req_n <= 1'b1;
         pll_relock_q     <= 1'b0;
         busy_q           <= 1'b0;
      end else if (ce) begin
         block_next_req_n <= !stall_d;
         pll_relock_q     <= stall_d;
         busy_q           <= (state_d != DVFS_IDLE);
      end
   end

   // ratio of core to bus clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_ratio_q <= RATIO_RESET;
         vtarget_q    <= VCODE_RESET;
         tgt_ratio_q  <= RATIO_RESET;
         tgt_vcode_q  <= VCODE_RESET;
      end else if (ce) begin
         if (idle_w && pend_valid_q) begin
            tgt_ratio_q <= pend_q[POINT_W-1 -: RATIO_W];
            tgt_vcode_q <= pend_q[VCODE_W-1:0];
            if (faster_w) begin
               vtarget_q <= pend_q[VCODE_W-1:0];
            end
         end
         if (state_q == DVFS_RELOCK && lock_end_w) begin
            core_ratio_q <= tgt_ratio_q;
            vtarget_q    <= tgt_vcode_q;
         end else if (state_q == DVFS_IDLE && pend_valid_q && !faster_w && !slower_w) begin
            vtarget_q <= pend_q[VCODE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q       <= '0;
         pend_valid_q <= 1'b0;
      end else if (ce) begin
         if (req_valid) begin
            pend_q       <= {req_ratio, req_vcode};
            pend_valid_q <= 1'b1;
         end else if (therm_down_go) begin
            pend_q       <= {therm_low_ratio, therm_low_vcode};
            pend_valid_q <= 1'b1;
         end else if (therm_up_go) begin
            pend_q       <= saved_q;
            pend_valid_q <= 1'b1;
         end else if (idle_w && pend_valid_q) begin
            pend_valid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         saved_q          <= '0;
         therm_active_q   <= 1'b0;
         twait_q          <= '0;
         therm_down_irq_q <= 1'b0;
         therm_up_irq_q   <= 1'b0;
      end else if (ce) begin
         therm_down_irq_q <= therm_down_go && !req_valid;
         therm_up_irq_q   <= therm_up_go && !req_valid;
         if (therm_down_go && !req_valid) begin
            saved_q        <= {core_ratio_q, vtarget_q};
            therm_active_q <= 1'b1;
            twait_q        <= '0;
         end else if (therm_up_go && !req_valid) begin
            therm_active_q <= 1'b0;
         end else if (therm_active_q) begin
            twait_q <= twait_end ? twait_q : twait_q + TWW'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         deep_q             <= 1'b0;
         power_status_low_n <= 1'b1;
      end else if (ce) begin
         if (!deep_sleep_req_n && sleep_state) begin
            deep_q <= 1'b1;
         end else if (deep_sleep_req_n) begin
            deep_q <= 1'b0;
         end
         power_status_low_n <= !((!deep_sleep_req_n && sleep_state) || (deep_q && !deep_sleep_req_n));
      end
   end

   property p_vup_first;
      @(posedge clk) disable iff (rst)
      pll_relock_q && up_w |-> code_now == tgt_vcode_q;
   endproperty
   a_vup_first: assert property (p_vup_first) else $error("relock before voltage reached");

   property p_vdn_after;
      @(posedge clk) disable iff (rst)
      (state_q == DVFS_VDN) |-> core_ratio_q == tgt_ratio_q;
   endproperty
   a_vdn_after: assert property (p_vdn_after) else $error("voltage drop before relock");

   property p_step;
      @(posedge clk) disable iff (rst)
      ce && $past(ce) |-> (code_now == $past(code_now)) || (code_now == $past(code_now) + VCODE_STEP)
                          || (code_now == $past(code_now) - VCODE_STEP);
   endproperty
   a_step: assert property (p_step) else $error("voltage code jumped");

   property p_stall_bound;
      @(posedge clk) disable iff (rst)
      lock_cnt_q <= LCW'(STALL_MAX_CYC);
   endproperty
   a_stall_bound: assert property (p_stall_bound) else $error("stall exceeded bound");

   property p_bnr;
      @(posedge clk) disable iff (rst)
      core_stall_q |-> !block_next_req_n;
   endproperty
   a_bnr: assert property (p_bnr) else $error("snoops not blocked");

   property p_defer;
      @(posedge clk) disable iff (rst)
      ce && req_valid |=> pend_valid_q;
   endproperty
   a_defer: assert property (p_defer) else $error("request lost");

   property p_down_irq;
      @(posedge clk) disable iff (rst)
      therm_down_irq_q |-> therm_active_q && saved_q == $past({core_ratio_q, vtarget_q});
   endproperty
   a_down_irq: assert property (p_down_irq) else $error("thermal drop state wrong");

   property p_psi;
      @(posedge clk) disable iff (rst)
      ce && deep_sleep_req_n |=> power_status_low_n;
   endproperty
   a_psi: assert property (p_psi) else $error("power status held after exit");

   c_up: cover property (@(posedge clk) disable iff (rst) state_q == DVFS_VUP ##[1:300] state_q == DVFS_DONE);
   c_down: cover property (@(posedge clk) disable iff (rst) therm_down_irq_q);
   c_back: cover property (@(posedge clk) disable iff (rst) therm_up_irq_q);
   c_defer: cover property (@(posedge clk) disable iff (rst) busy_q && req_valid);
endmodule

// ==== tb/dvfs_far_model.sv ====
`timescale 1ns/10ps
// far side: pll lock response, chipset bus requests, sleep control
module dvfs_far_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pll_relock_q,
   input  wire logic [15:0] lock_dly,
   input  wire logic        sleep_state,
   input  wire logic        go_deep,
   input  wire logic        data_activity,
   input  wire logic        bus_master,
   output logic             pll_locked,
   output logic             deep_sleep_req_n,
   output logic             data_buffer_power_req_n,
   output logic             priority_agent_req_n
);
   logic [15:0] lock_cnt_q;
   // lock time set by bench, may run past the stall cap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_cnt_q <= 16'h0000;
         pll_locked <= 1'b0;
      end else if (!pll_relock_q) begin
         lock_cnt_q <= 16'h0000;
         pll_locked <= 1'b0;
      end else begin
         lock_cnt_q <= lock_cnt_q + 16'h0001;
         pll_locked <= (lock_cnt_q + 16'h0001 >= lock_dly);
      end
   end
   assign deep_sleep_req_n = ~(go_deep & sleep_state);
   assign data_buffer_power_req_n = ~data_activity;
   assign priority_agent_req_n = ~bus_master;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   import dvfs_pkg::*;
   localparam int unsigned LINES = 8;
   logic             clk, rst, ce, req_valid, therm_enable, therm_hot, pll_locked, sleep_state;
   logic             go_deep, data_activity, bus_master, deep_sleep_req_n, data_buffer_power_req_n;
   logic             priority_agent_req_n, pll_relock_q, block_next_req_n, core_stall_q, busy_q;
   logic             therm_active_q, therm_down_irq_q, therm_up_irq_q, power_status_low_n;
   logic             data_buf_en_q, addr_buf_en_q;
   logic [5:0]       req_vcode, req_ratio, therm_low_vcode, therm_low_ratio, voltage_code_out, core_ratio_q;
   logic [5:0]       rl_code;
   logic [LINES-1:0] line_drive_low, odt_en_q;
   logic [15:0]      lock_dly;
   int               err_count, n_compared, cyc, n_down, n_up, st_cnt, rl_seen, saw8;

   dvfs_ctrl #(.RAMP_CYC(2), .THERM_WAIT(50), .LINES(LINES)) u_dut (
      .clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_vcode(req_vcode), .req_ratio(req_ratio),
      .therm_low_vcode(therm_low_vcode), .therm_low_ratio(therm_low_ratio), .therm_enable(therm_enable),
      .therm_hot(therm_hot), .pll_locked(pll_locked), .sleep_state(sleep_state),
      .deep_sleep_req_n(deep_sleep_req_n), .data_buffer_power_req_n(data_buffer_power_req_n),
      .priority_agent_req_n(priority_agent_req_n), .line_drive_low(line_drive_low),
      .voltage_code_out(voltage_code_out), .core_ratio_q(core_ratio_q), .pll_relock_q(pll_relock_q),
      .block_next_req_n(block_next_req_n), .core_stall_q(core_stall_q), .busy_q(busy_q),
      .therm_active_q(therm_active_q), .therm_down_irq_q(therm_down_irq_q), .therm_up_irq_q(therm_up_irq_q),
      .power_status_low_n(power_status_low_n), .data_buf_en_q(data_buf_en_q), .addr_buf_en_q(addr_buf_en_q),
      .odt_en_q(odt_en_q));

   dvfs_far_model u_far (
      .clk(clk), .rst(rst), .pll_relock_q(pll_relock_q), .lock_dly(lock_dly), .sleep_state(sleep_state),
      .go_deep(go_deep), .data_activity(data_activity), .bus_master(bus_master), .pll_locked(pll_locked),
      .deep_sleep_req_n(deep_sleep_req_n), .data_buffer_power_req_n(data_buffer_power_req_n),
      .priority_agent_req_n(priority_agent_req_n));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // slow relock alone takes about 2000 cycles
   always @(posedge clk) begin
      cyc++;
      if (therm_down_irq_q === 1'b1)
         n_down++;
      if (therm_up_irq_q === 1'b1)
         n_up++;
      if (cyc == 30000) begin
         err_count++;
         $display("ERROR %0t run did not finish", $time);
         final_report();
      end
   end

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic request(input logic [5:0] r, input logic [5:0] v);
      req_ratio = r;
      req_vcode = v;
      req_valid = 1'b1;
      step();
      req_valid = 1'b0;
   endtask

   // follows transitions until busy has stayed low four cycles
   task automatic watch();
      int seen;
      int quiet;
      logic [5:0] prev;
      seen = 0;
      quiet = 0;
      st_cnt = 0;
      rl_seen = 0;
      saw8 = 0;
      prev = voltage_code_out;
      for (int i = 0; i < 6000 && quiet < 4; i++) begin
         step();
         quiet = (busy_q === 1'b1) ? 0 : quiet + seen;
         seen = seen | (busy_q === 1'b1);
         chk_bit(voltage_code_out - prev <= 6'h01 || prev - voltage_code_out <= 6'h01, 1'b1, "code step");
         chk_bit(block_next_req_n, ~pll_relock_q, "snoop block");
         prev = voltage_code_out;
         st_cnt += (core_stall_q === 1'b1);
         saw8 |= (core_ratio_q === 6'h08);
         if (pll_relock_q === 1'b1 && rl_seen == 0)
            rl_code = voltage_code_out;
         rl_seen |= (pll_relock_q === 1'b1);
      end
      chk_bit(quiet >= 4, 1'b1, "transition end");
      chk_bit(st_cnt <= STALL_MAX_CYC, 1'b1, "stall length");
   endtask

   task automatic t_reset();
      chk_vec(voltage_code_out, 8'h3F, "reset code");
      chk_vec(core_ratio_q, 8'h01, "reset ratio");
      chk_bit(block_next_req_n, 1'b1, "reset snoop block");
      chk_bit(power_status_low_n, 1'b1, "reset power status");
      chk_vec(odt_en_q, 8'hFF, "reset termination");
   endtask

   task automatic t_faster();
      lock_dly = 16'h0005;
      request(6'h04, 6'h3A);
      watch();
      chk_vec(rl_code, 8'h3A, "code before relock");
      chk_vec(core_ratio_q, 8'h04, "ratio after");
      chk_vec(voltage_code_out, 8'h3A, "code after");
   endtask

   // lock never comes in time: stall must still end at the cap
   task automatic t_slower_slow_lock();
      lock_dly = 16'h0BB8;
      request(6'h02, 6'h3D);
      watch();
      chk_vec(rl_code, 8'h3A, "code during relock");
      chk_bit(st_cnt > 0, 1'b1, "stall seen");
      chk_vec(core_ratio_q, 8'h02, "ratio after");
      chk_vec(voltage_code_out, 8'h3D, "code after");
   endtask

   task automatic t_defer();
      lock_dly = 16'h0005;
      request(6'h08, 6'h38);
      repeat (4) step();
      request(6'h03, 6'h3C);
      watch();
      chk_bit(saw8 != 0, 1'b1, "first point reached");
      chk_vec(core_ratio_q, 8'h03, "deferred ratio");
      chk_vec(voltage_code_out, 8'h3C, "deferred code");
   endtask

   task automatic t_thermal();
      int d0;
      int u0;
      d0 = n_down;
      u0 = n_up;
      therm_low_ratio = 6'h01;
      therm_low_vcode = 6'h3E;
      therm_enable = 1'b1;
      therm_hot = 1'b1;
      watch();
      chk_vec(core_ratio_q, 8'h01, "throttle ratio");
      chk_vec(voltage_code_out, 8'h3E, "throttle code");
      chk_vec(n_down - d0, 8'h01, "down interrupts");
      chk_bit(therm_active_q, 1'b1, "throttle flag");
      therm_hot = 1'b0;
      watch();
      chk_vec(core_ratio_q, 8'h03, "restored ratio");
      chk_vec(voltage_code_out, 8'h3C, "restored code");
      chk_vec(n_up - u0, 8'h01, "up interrupts");
      chk_bit(therm_active_q, 1'b0, "throttle flag cleared");
      therm_enable = 1'b0;
   endtask

   task automatic t_bus_gates();
      // enable low must freeze the gate flops
      ce = 1'b0;
      data_activity = 1'b1;
      step();
      chk_bit(data_buf_en_q, 1'b0, "enable low holds buffers");
      ce = 1'b1;
      step();
      chk_bit(data_buf_en_q, 1'b1, "data buffers on");
      data_activity = 1'b0;
      step();
      chk_bit(data_buf_en_q, 1'b0, "data buffers off");
      bus_master = 1'b1;
      step();
      chk_bit(addr_buf_en_q, 1'b1, "address buffers on");
      bus_master = 1'b0;
      step();
      chk_bit(addr_buf_en_q, 1'b0, "address buffers off");
      line_drive_low = 8'hA5;
      step();
      chk_vec(odt_en_q, 8'h5A, "termination off when low");
      line_drive_low = 8'h00;
      step();
      chk_vec(odt_en_q, 8'hFF, "termination back on");
   endtask

   task automatic t_power_status();
      sleep_state = 1'b1;
      step();
      chk_bit(power_status_low_n, 1'b1, "sleep only");
      go_deep = 1'b1;
      step();
      chk_bit(power_status_low_n, 1'b0, "deep entry");
      repeat (5) step();
      chk_bit(power_status_low_n, 1'b0, "deep held");
      go_deep = 1'b0;
      step();
      chk_bit(power_status_low_n, 1'b1, "deep exit");
      sleep_state = 1'b0;
   endtask

   initial begin
      err_count = 0;
      n_compared = 0;
      cyc = 0;
      n_down = 0;
      n_up = 0;
      rst = 1'b1;
      ce = 1'b1;
      req_valid = 1'b0;
      req_vcode = 6'h3F;
      req_ratio = 6'h01;
      therm_low_vcode = 6'h3F;
      therm_low_ratio = 6'h01;
      therm_enable = 1'b0;
      therm_hot = 1'b0;
      sleep_state = 1'b0;
      go_deep = 1'b0;
      data_activity = 1'b0;
      bus_master = 1'b0;
      line_drive_low = 8'h00;
      lock_dly = 16'h0005;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      step();
      t_reset();
      t_faster();
      t_slower_slow_lock();
      t_defer();
      t_thermal();
      t_bus_gates();
      t_power_status();
      final_report();
   end
endmodule
